/* src/gate_driver_spi_and_power_state.sv */
/*
 * power states, latched faults and registers behind the serial port.
 * assumes a serial clock from the master and analog drivers obeying power_ctl_o.
 */
// How it works
// RL1: enable low: drivers, pump, regulators, serial port asleep
// RL2: sleep only after full sleep-entry delay from enable fall
// RL3: enable high wakes alone; controller waits wake delay
// RL4: sleep or supply low: gates tied to switch node, ground
// RL5: alert low while regulators switch, within sleep or wake delay
// RL6: enable high, supply good: all blocks active
// RL7: latched fault shuts gate drive until cleared
// RL8: command bit or enable pulse clears faults whose cause is gone
// RL9: short enable low clears; longer low shuts down into sleep
// RL10: enable pulse clears latched faults only
// RL11: frame is 5 command then 11 data bits
// RL12: answer is 5 don't-care then 11 data bits
// RL13: controller holds serial clock low at select edges
// RL14: controller holds select high 400 ns between frames
// RL15: select high: clock, data ignored, output floats
// RL16: sample on serial clock fall, change on rise
// RL17: msb first both ways
// RL18: only exactly 16 clocks valid; else error, discard
// RL19: bit 15 read/write flag, 14..11 address, 10..0 data
// RL20: write returns prior content, read current content
// RL21: write lands at select release after exactly 16 clocks
// RL22: summary bit is or of faults, matches alert pin
// RL23: status registers read-only
`timescale 1ns/1ns
module gate_driver_spi_and_power_state
    import gd_pkg::*;
#(
    parameter int SLEEP_CYCLES = SLEEP_ENTRY_CYCLES,
    parameter int WAKE_DELAY_CYCLES = WAKE_CYCLES,
    parameter int PULSE_CYCLES = RESET_PULSE_CYCLES
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clock_enable_i,
    input wire logic enable_pin_i,
    input wire logic motor_supply_ok_i,
    input wire logic [FAULT_SRC_W-1:0] fault_sources_i,
    input wire logic [DATA_BITS-1:0] warning_status_i,
    input wire logic serial_clock_i,
    input wire logic select_low_pin_i,
    input wire logic serial_in_pin_i,
    output logic serial_out_pin_o,
    output logic serial_out_pin_en_o,
    output logic error_alert_low_o,
    output logic frame_error_o,
    output power_ctl_t power_ctl_o,
    output logic [REG_COUNT-1:REG_DRIVER_CTRL][DATA_BITS-1:0] config_o
);
    localparam logic [DELAY_COUNT_W-1:0] SLEEP_LAST = DELAY_COUNT_W'(SLEEP_CYCLES - 1);

    localparam logic [DELAY_COUNT_W-1:0] WAKE_LAST = DELAY_COUNT_W'(WAKE_DELAY_CYCLES - 1);

    localparam logic [DELAY_COUNT_W-1:0] PULSE_LAST = DELAY_COUNT_W'(PULSE_CYCLES - 1);

    //////////////////////////////
    // synchronisers

    logic enable_sync;

    logic supply_sync;

    logic select_sync;

    logic [FAULT_SRC_W-1:0] fault_sync;

    logic [DATA_BITS-1:0] warning_sync;

    sync_2ff #(
        .WIDTH(3),
        .RESET_VALUE(3'h1)
    ) u_sync_levels (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .clock_enable_i(clock_enable_i),
        .async_i({enable_pin_i, motor_supply_ok_i, select_low_pin_i}),
        .sync_o({enable_sync, supply_sync, select_sync})
    );

    sync_2ff #(
        .WIDTH(FAULT_SRC_W + DATA_BITS),
        .RESET_VALUE('0)
    ) u_sync_status (
        .clock_i(clock_i),
        .reset_i(reset_i),
        .clock_enable_i(clock_enable_i),
        .async_i({fault_sources_i, warning_status_i}),
        .sync_o({fault_sync, warning_sync})
    );

    //////////////////////////////
    // link side

    logic [REG_COUNT-1:0][DATA_BITS-1:0] snapshot_reg;

    logic [FRAME_BITS-1:0] link_word;

    logic [COUNT_W-1:0] link_count;

    logic link_out;

    serial_link u_link (
        .serial_clock_i(serial_clock_i),
        .select_low_pin_i(select_low_pin_i),
        .serial_in_pin_i(serial_in_pin_i),
        .snapshot_i(snapshot_reg),
        .word_o(link_word),
        .bit_count_o(link_count),
        .serial_out_o(link_out)
    );

    assign serial_out_pin_o = link_out;

    // floats while deselected or powered down
    assign serial_out_pin_en_o = ~select_low_pin_i & power_ctl_o.serial_port_en; // RL15 RL1

    //////////////////////////////
    // frame end: link outputs are still once select rose

    logic select_prev_reg;

    logic frame_end;

    frame_t frame;

    logic frame_ok;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            select_prev_reg <= 1'b1;
        else if (clock_enable_i)
            select_prev_reg <= select_sync;
    end

    assign frame_end = select_sync & ~select_prev_reg & power_ctl_o.serial_port_en; // RL21

    assign frame = frame_t'(link_word); // RL11 RL19

    assign frame_ok = (link_count == COUNT_FULL); // RL18

    function automatic logic is_writable(input logic [ADDR_BITS-1:0] addr);
        is_writable = (addr >= REG_DRIVER_CTRL) && (addr < ADDR_BITS'(REG_COUNT)); // RL23
    endfunction : is_writable

    logic write_hit;

    logic clear_cmd;
    assign write_hit = frame_end & frame_ok & ~frame.read_write_flag & is_writable(frame.addr);
    assign clear_cmd = write_hit & (frame.addr == REG_DRIVER_CTRL)
        & frame.data[CLEAR_BIT_POS]; // RL8

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            frame_error_o <= 1'b0;
        else if (clock_enable_i && frame_end)
            frame_error_o <= ~frame_ok; // RL18
    end

    //////////////////////////////
    // configuration registers

    genvar gi;

    generate
        for (gi = REG_DRIVER_CTRL; gi < REG_COUNT; gi++)
        begin : g_config
            always_ff @(posedge clock_i)
            begin
                if (reset_i)
                    config_o[gi] <= CONFIG_RESET;
                else if (clock_enable_i && write_hit && frame.addr == ADDR_BITS'(gi))
                begin
                    // the clear bit is never stored
                    if (gi == REG_DRIVER_CTRL)
                        config_o[gi] <= frame.data & ~(DATA_BITS'(1) << CLEAR_BIT_POS); // RL21
                    else
                        config_o[gi] <= frame.data; // RL21
                end
            end
        end
    endgenerate

    //////////////////////////////
    // power state

    power_state_t state_reg;

    power_state_t state_next;

    logic [DELAY_COUNT_W-1:0] delay_reg;

    logic [DELAY_COUNT_W-1:0] delay_next;

    logic pulse_clear;

    always_comb
    begin
        state_next = state_reg;
        delay_next = delay_reg + DELAY_COUNT_W'(1);
        pulse_clear = 1'b0;
        case (state_reg)
            PWR_SLEEP:
            begin
                delay_next = '0;
                if (enable_sync)
                    state_next = PWR_WAKE; // RL3
            end

            PWR_WAKE:
            begin
                if (!enable_sync)
                begin
                    state_next = PWR_SHUTDOWN;
                    delay_next = '0;
                end
                else if (delay_reg == WAKE_LAST)
                    state_next = PWR_ACTIVE; // RL3 RL6
            end

            PWR_ACTIVE:
            begin
                delay_next = '0;
                if (!enable_sync)
                    state_next = PWR_PULSE;
            end

            PWR_PULSE:
            begin
                if (enable_sync)
                begin
                    state_next = PWR_ACTIVE; // RL9
                    pulse_clear = 1'b1; // RL10
                end
                else if (delay_reg == PULSE_LAST)
                    state_next = PWR_SHUTDOWN; // RL9
            end

            PWR_SHUTDOWN:
            begin
                // counts on from the enable fall
                if (delay_reg == SLEEP_LAST)
                    state_next = PWR_SLEEP; // RL2
            end

            default:
            begin
                state_next = PWR_SLEEP;
                delay_next = '0;
            end
        endcase
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            state_reg <= PWR_SLEEP;
            delay_reg <= '0;
        end
        else if (clock_enable_i)
        begin
            state_reg <= state_next;
            delay_reg <= delay_next;
        end
    end

    //////////////////////////////
    // latched faults

    logic [FAULT_SRC_W-1:0] fault_latch_reg;

    logic clear_any;

    logic fault_summary;

    assign clear_any = clear_cmd | pulse_clear;

    // a fault present in the clear cycle stays latched
    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            fault_latch_reg <= '0;
        else if (clock_enable_i)
            fault_latch_reg <= (fault_latch_reg & ~({FAULT_SRC_W{clear_any}} & ~fault_sync))
                | fault_sync; // RL8
    end

    logic regulators_switching;

    assign regulators_switching = (state_reg == PWR_WAKE) || (state_reg == PWR_SHUTDOWN);
    assign fault_summary = (|fault_latch_reg) | regulators_switching; // RL22

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            error_alert_low_o <= 1'b1;
        else if (clock_enable_i)
            error_alert_low_o <= ~((|fault_latch_reg) | (state_next == PWR_WAKE)
                | (state_next == PWR_SHUTDOWN)); // RL5 RL22
    end

    //////////////////////////////
    // power control outputs

    logic operating;

    assign operating = ((state_next == PWR_ACTIVE) || (state_next == PWR_PULSE)) & supply_sync;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            power_ctl_o <= '{gate_tie: 1'b1, default: 1'b0};
        else if (clock_enable_i)
        begin
            power_ctl_o.gate_enable <= operating & ~(|fault_latch_reg); // RL7 RL4
            power_ctl_o.gate_tie <= (state_next == PWR_SLEEP) | ~supply_sync; // RL4
            power_ctl_o.charge_pump_en <= operating; // RL6 RL1
            power_ctl_o.low_gate_reg_en <= operating; // RL6 RL1
            power_ctl_o.logic_supply_regulator_en <= (state_next != PWR_SLEEP); // RL1 RL6
            power_ctl_o.serial_port_en <= operating; // RL6 RL1
        end
    end

    //////////////////////////////
    // read snapshot, frozen during a frame

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
            snapshot_reg <= '0;
        else if (clock_enable_i && select_sync)
        begin
            snapshot_reg[REG_FAULT_STATUS[REG_IDX_W-1:0]] <= {fault_summary, fault_latch_reg};
            snapshot_reg[REG_WARN_STATUS[REG_IDX_W-1:0]] <= warning_sync;
            for (int i = REG_DRIVER_CTRL; i < REG_COUNT; i++)
                snapshot_reg[i] <= config_o[i]; // RL20
        end
    end

endmodule : gate_driver_spi_and_power_state

/* src/gd_pkg.sv */
/*
 * constants and types of the gate driver block.
 * assumes a 20 MHz clock; delays are plain defaults.
 */
package gd_pkg;

    // system clock
    localparam int CLK_PERIOD_NS = 50;

    // power-state timing, ns
    localparam int SLEEP_ENTRY_DELAY_NS = 1000000;
    localparam int WAKE_DELAY_NS = 1000000;
    localparam int RESET_PULSE_WINDOW_NS = 8000;

    // least times round up
    localparam int SLEEP_ENTRY_CYCLES = (SLEEP_ENTRY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAKE_CYCLES = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // a longest time rounds down
    localparam int RESET_PULSE_CYCLES = RESET_PULSE_WINDOW_NS / CLK_PERIOD_NS;
    localparam int DELAY_COUNT_W = 16;

    // serial word layout
    localparam int FRAME_BITS = 16;
    localparam int COMMAND_BITS = 5;
    localparam int DATA_BITS = 11;
    localparam int ADDR_BITS = 4;
    localparam int RW_POS = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 11;
    localparam int COUNT_W = 5;
    localparam logic [COUNT_W-1:0] COUNT_FULL = 5'h10;
    localparam logic [COUNT_W-1:0] COUNT_CMD = 5'h05;
    localparam logic [COUNT_W-1:0] COUNT_OVER = 5'h11;

    // register map
    localparam int REG_COUNT = 8;
    localparam int REG_IDX_W = 3;
    localparam logic [ADDR_BITS-1:0] REG_FAULT_STATUS = 4'h0;
    localparam logic [ADDR_BITS-1:0] REG_WARN_STATUS = 4'h1;
    localparam logic [ADDR_BITS-1:0] REG_DRIVER_CTRL = 4'h2;
    localparam int CLEAR_BIT_POS = 0;
    localparam int SUMMARY_BIT_POS = 10;
    localparam int FAULT_SRC_W = 10;
    localparam logic [DATA_BITS-1:0] CONFIG_RESET = 11'h000;

    typedef struct packed {
        logic read_write_flag;
        logic [ADDR_BITS-1:0] addr;
        logic [DATA_BITS-1:0] data;
    } frame_t;

    typedef struct packed {
        logic gate_enable;
        logic gate_tie;
        logic charge_pump_en;
        logic low_gate_reg_en;
        logic logic_supply_regulator_en;
        logic serial_port_en;
    } power_ctl_t;

    typedef enum logic [2:0] {
        PWR_SLEEP = 3'b000,
        PWR_WAKE = 3'b001,
        PWR_ACTIVE = 3'b010,
        PWR_PULSE = 3'b011,
        PWR_SHUTDOWN = 3'b100
    } power_state_t;

endpackage : gd_pkg

/* src/sync_2ff.sv */
/*
 * two-flop synchroniser with clock enable.
 * assumes level inputs from pins or another clock.
 */
`timescale 1ns/1ns
module sync_2ff #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic clock_enable_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);
    logic [WIDTH-1:0] meta_reg;

    always_ff @(posedge clock_i)
    begin
        if (reset_i)
        begin
            meta_reg <= RESET_VALUE;
            sync_o <= RESET_VALUE;
        end
        else if (clock_enable_i)
        begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end
endmodule : sync_2ff

/* src/serial_link.sv */
/*
 * link side: shifts the command in and the answer out.
 * assumes the clock idles low and the snapshot holds still in a frame.
 */
`timescale 1ns/1ns
module serial_link
    import gd_pkg::*;
(
    input wire logic serial_clock_i,
    input wire logic select_low_pin_i,
    input wire logic serial_in_pin_i,
    input wire logic [REG_COUNT-1:0][DATA_BITS-1:0] snapshot_i,
    output logic [FRAME_BITS-1:0] word_o,
    output logic [COUNT_W-1:0] bit_count_o,
    output logic serial_out_o
);
    logic fresh_reg;
    logic [DATA_BITS-1:0] out_shift_reg;
    logic [DATA_BITS-1:0] read_value;

    // first fall restarts the count; select high re-arms
    always_ff @(negedge serial_clock_i or posedge select_low_pin_i)
    begin
        if (select_low_pin_i)
            fresh_reg <= 1'b1;
        else
            fresh_reg <= 1'b0;
    end

    // capture on fall; word and count hold after the frame
    always_ff @(negedge serial_clock_i)
    begin
        if (fresh_reg)
        begin
            word_o <= {{(FRAME_BITS-1){1'b0}}, serial_in_pin_i}; // RL16 RL17
            bit_count_o <= 5'h01;
        end
        else
        begin
            word_o <= {word_o[FRAME_BITS-2:0], serial_in_pin_i}; // RL16 RL17
            if (bit_count_o != COUNT_OVER)
                bit_count_o <= bit_count_o + 5'h01; // RL18
        end
    end

    // after five bits the low bits hold flag and address
    always_comb
    begin
        if (word_o[ADDR_BITS-1])
            read_value = '0;
        else
            read_value = snapshot_i[word_o[REG_IDX_W-1:0]]; // RL20
    end

    // launch on rise: five zero bits, then eleven data bits
    always_ff @(posedge serial_clock_i or posedge select_low_pin_i)
    begin
        if (select_low_pin_i)
        begin
            out_shift_reg <= '0;
            serial_out_o <= 1'b0;
        end
        else if (!fresh_reg && bit_count_o == COUNT_CMD)
        begin
            serial_out_o <= read_value[DATA_BITS-1]; // RL12 RL16
            out_shift_reg <= {read_value[DATA_BITS-2:0], 1'b0};
        end
        else if (!fresh_reg && bit_count_o > COUNT_CMD)
        begin
            serial_out_o <= out_shift_reg[DATA_BITS-1]; // RL17
            out_shift_reg <= {out_shift_reg[DATA_BITS-2:0], 1'b0};
        end
        else
            serial_out_o <= 1'b0;
    end
endmodule : serial_link

/* tb/gd_sva.sv */
/*
 * checker of the gate driver block.
 * assumes the bench's short delays and a steady clock enable.
 */
`timescale 1ns/1ns
module gd_sva
    import gd_pkg::*;
#(
    parameter int SLEEP_CYCLES = 20,
    parameter int WAKE_DELAY_CYCLES = 20,
    parameter int PULSE_CYCLES = 4
) (
    input wire logic clock_i,
    input wire logic reset_i,
    input wire logic enable_pin_i,
    input wire logic motor_supply_ok_i,
    input wire logic [FAULT_SRC_W-1:0] fault_sources_i,
    input wire logic select_low_pin_i,
    input wire logic serial_out_pin_en_o,
    input wire logic error_alert_low_o,
    input wire logic frame_error_o,
    input wire power_ctl_t power_ctl_o,
    input wire logic [REG_COUNT-1:REG_DRIVER_CTRL][DATA_BITS-1:0] config_o
);
    logic [7:0] low_cnt_reg;
    logic [7:0] high_cnt_reg;

    default clocking @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // enable low and high run lengths
    always_ff @(posedge clock_i)
    begin
        if (reset_i || enable_pin_i)
            low_cnt_reg <= 8'h00;
        else if (low_cnt_reg != 8'hFF)
            low_cnt_reg <= low_cnt_reg + 8'h01;
    end

    always_ff @(posedge clock_i)
    begin
        if (reset_i || !enable_pin_i)
            high_cnt_reg <= 8'h00;
        else if (high_cnt_reg != 8'hFF)
            high_cnt_reg <= high_cnt_reg + 8'h01;
    end

    //////////////////////////////
    property p_sleep_off;
        !power_ctl_o.logic_supply_regulator_en |-> !power_ctl_o.charge_pump_en
            && !power_ctl_o.serial_port_en && !power_ctl_o.gate_enable && power_ctl_o.gate_tie;
    endproperty
    a_sleep_off: assert property (p_sleep_off)
        else $error("block on in sleep");

    property p_sleep_reached;
        int'(low_cnt_reg) == SLEEP_CYCLES + PULSE_CYCLES + 8 |->
            !power_ctl_o.logic_supply_regulator_en && !power_ctl_o.low_gate_reg_en
            && error_alert_low_o;
    endproperty
    a_sleep_reached: assert property (p_sleep_reached)
        else $error("no sleep");

    property p_sleep_delay;
        $fell(enable_pin_i) && error_alert_low_o && power_ctl_o.serial_port_en |->
            power_ctl_o.logic_supply_regulator_en [*8];
    endproperty
    a_sleep_delay: assert property (p_sleep_delay)
        else $error("early sleep");

    property p_wake_alert;
        $rose(power_ctl_o.logic_supply_regulator_en) && fault_sources_i == 10'h000 |->
            ##1 !error_alert_low_o ##[1:40] error_alert_low_o;
    endproperty
    a_wake_alert: assert property (p_wake_alert)
        else $error("wake alert");

    property p_supply_low;
        (!motor_supply_ok_i) [*4] |-> power_ctl_o.gate_tie && !power_ctl_o.gate_enable;
    endproperty
    a_supply_low: assert property (p_supply_low)
        else $error("gates on, supply low");

    property p_operating;
        int'(high_cnt_reg) == SLEEP_CYCLES + WAKE_DELAY_CYCLES + PULSE_CYCLES + 16
            && motor_supply_ok_i |-> power_ctl_o.serial_port_en
            && power_ctl_o.charge_pump_en && power_ctl_o.low_gate_reg_en;
    endproperty
    a_operating: assert property (p_operating)
        else $error("not operating");

    property p_fault_shut;
        (fault_sources_i != 10'h000 && power_ctl_o.serial_port_en) [*6] |->
            !power_ctl_o.gate_enable && !error_alert_low_o;
    endproperty
    a_fault_shut: assert property (p_fault_shut)
        else $error("fault kept gates");

    property p_float;
        select_low_pin_i |-> !serial_out_pin_en_o;
    endproperty
    a_float: assert property (p_float)
        else $error("out driven, deselected");

    property p_cfg_hold;
        select_low_pin_i [*5] |-> $stable(config_o);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold)
        else $error("config changed");

    property p_err_hold;
        select_low_pin_i [*5] |-> $stable(frame_error_o);
    endproperty
    a_err_hold: assert property (p_err_hold)
        else $error("frame error changed");

    c_frame_err: cover property ($rose(frame_error_o));
    c_alert: cover property ($fell(error_alert_low_o));
    c_sleep: cover property ($fell(power_ctl_o.logic_supply_regulator_en));
endmodule : gd_sva

bind gate_driver_spi_and_power_state gd_sva #(
    .SLEEP_CYCLES(SLEEP_CYCLES),
    .WAKE_DELAY_CYCLES(WAKE_DELAY_CYCLES),
    .PULSE_CYCLES(PULSE_CYCLES)
) i_gd_sva (
    .clock_i,
    .reset_i,
    .enable_pin_i,
    .motor_supply_ok_i,
    .fault_sources_i,
    .select_low_pin_i,
    .serial_out_pin_en_o,
    .error_alert_low_o,
    .frame_error_o,
    .power_ctl_o,
    .config_o
);

/* tb/gd_master.sv */
/*
 * master controller model of the serial port.
 * assumes frames start just after a system clock edge.
 */
`timescale 1ns/1ns
module gd_master (
    output logic serial_clock_o,
    output logic select_low_pin_o,
    output logic serial_in_pin_o,
    input wire logic serial_out_pin_i,
    input wire logic serial_out_pin_en_i
);
    initial
    begin
        serial_clock_o = 1'b0;
        select_low_pin_o = 1'b0;
        serial_in_pin_o = 1'b0;
        // a real select rise arms the link
        #1 select_low_pin_o = 1'b1;
    end

    // extra adds or drops clocks past sixteen
    task automatic xfer(input logic [15:0] word, input int extra, output logic [15:0] answer);
        select_low_pin_o = 1'b0;
        #120;
        for (int i = 0; i < 16 + extra; i++)
        begin
            serial_clock_o = 1'b1;
            serial_in_pin_o = (i < 16) ? word[15 - i] : ~serial_in_pin_o;
            #40;
            serial_clock_o = 1'b0;
            if (i < 16)
                answer[15 - i] = serial_out_pin_en_i ? serial_out_pin_i : 1'bx;
            #40;
        end
        select_low_pin_o = 1'b1;
        serial_in_pin_o = ~serial_in_pin_o;
        #500;
    endtask : xfer
endmodule : gd_master

/* tb/testbench.sv */
/*
 * self-checking bench of the gate driver block.
 * assumes short delays; the master model makes the serial clock.
 */
`timescale 1ns/1ns
module testbench;
    import gd_pkg::*;
    logic clock_i = 1'b0;
    logic reset_i = 1'b1;
    logic enable_pin_i = 1'b0;
    logic motor_supply_ok_i = 1'b1;
    logic [FAULT_SRC_W-1:0] fault_sources_i = 10'h000;
    logic [DATA_BITS-1:0] warning_status_i = 11'h2A3;
    logic serial_clock_i, select_low_pin_i, serial_in_pin_i;
    logic serial_out_pin_o, serial_out_pin_en_o, error_alert_low_o, frame_error_o;
    power_ctl_t power_ctl_o;
    logic [REG_COUNT-1:REG_DRIVER_CTRL][DATA_BITS-1:0] config_o;
    logic [15:0] answer;
    int error_cnt = 0;
    int checked = 0;

    always #25 clock_i = ~clock_i;

    gate_driver_spi_and_power_state #(
        .SLEEP_CYCLES(20),
        .WAKE_DELAY_CYCLES(20),
        .PULSE_CYCLES(4)
    ) i_gate_driver_spi_and_power_state (
        .clock_i,
        .reset_i,
        .clock_enable_i(1'b1),
        .enable_pin_i,
        .motor_supply_ok_i,
        .fault_sources_i,
        .warning_status_i,
        .serial_clock_i,
        .select_low_pin_i,
        .serial_in_pin_i,
        .serial_out_pin_o,
        .serial_out_pin_en_o,
        .error_alert_low_o,
        .frame_error_o,
        .power_ctl_o,
        .config_o
    );

    gd_master i_gd_master (
        .serial_clock_o(serial_clock_i),
        .select_low_pin_o(select_low_pin_i),
        .serial_in_pin_o(serial_in_pin_i),
        .serial_out_pin_i(serial_out_pin_o),
        .serial_out_pin_en_i(serial_out_pin_en_o)
    );

    //////////////////////////////
    task automatic print_verdict;
        $display("checks %0d errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk_word

    task automatic chk_bit(input string name, input logic exp, input logic got);
        chk_word(name, {15'h0000, exp}, {15'h0000, got});
    endtask : chk_bit

    task automatic cycles(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : cycles

    // sel 0: serial port enable, 1: alert
    task automatic wait_for(input string name, input int sel, input logic val);
        int n = 0;
        while (((sel == 0) ? power_ctl_o.serial_port_en : error_alert_low_o) !== val)
        begin
            cycles(1);
            n++;
            if (n > 200)
            begin
                error_cnt++;
                $display("BAD %s expected %h seen timeout", name, val);
                print_verdict();
            end
        end
    endtask : wait_for

    task automatic frame(input logic [15:0] word, input int extra);
        @(posedge clock_i);
        #7;
        i_gd_master.xfer(word, extra, answer);
    endtask : frame

    //////////////////////////////
    task automatic t_wake;
        @(posedge clock_i);
        enable_pin_i <= 1'b1;
        cycles(21);
        chk_bit("port early", 1'b0, power_ctl_o.serial_port_en);
        wait_for("port on", 0, 1'b1);
        chk_bit("pump", 1'b1, power_ctl_o.charge_pump_en);
        wait_for("alert off", 1, 1'b1);
    endtask : t_wake

    task automatic t_regs;
        frame(16'h1DA5, 0);
        chk_word("write answer", 16'h0000, answer);
        chk_word("config 3", 16'h05A5, {5'h00, config_o[3]});
        frame(16'h9800, 0);
        chk_word("read 3", 16'h05A5, answer);
        frame(16'h8800, 0);
        chk_word("read 1", 16'h02A3, answer);
        frame(16'h07FF, 0);
        frame(16'h8000, 0);
        chk_word("status", 16'h0000, answer);
        frame(16'h3FFF, 0);
        chk_word("config 7", 16'h07FF, {5'h00, config_o[7]});
        frame(16'hC800, 0);
        chk_word("unmapped", 16'h0000, answer);
    endtask : t_regs

    task automatic t_frame_err;
        for (int e = -1; e <= 1; e += 2)
        begin
            frame(16'h2123, e);
            chk_bit("frame error", 1'b1, frame_error_o);
            chk_word("config 4", 16'h0000, {5'h00, config_o[4]});
        end
        frame(16'h9800, 0);
        chk_bit("frame ok", 1'b0, frame_error_o);
    endtask : t_frame_err

    task automatic t_fault;
        @(posedge clock_i);
        fault_sources_i <= 10'h008;
        cycles(8);
        chk_bit("gate off", 1'b0, power_ctl_o.gate_enable);
        frame(16'h8000, 0);
        chk_word("fault status", 16'h0408, answer);
        @(posedge clock_i);
        fault_sources_i <= 10'h000;
        cycles(8);
        chk_bit("latched", 1'b0, error_alert_low_o);
        frame(16'h1001, 0);
        wait_for("cleared", 1, 1'b1);
        chk_bit("gate on", 1'b1, power_ctl_o.gate_enable);
        chk_word("config 2", 16'h0000, {5'h00, config_o[2]});
    endtask : t_fault

    task automatic t_pulse;
        @(posedge clock_i);
        fault_sources_i <= 10'h002;
        cycles(8);
        @(posedge clock_i);
        fault_sources_i <= 10'h000;
        enable_pin_i <= 1'b0;
        repeat (3) @(posedge clock_i);
        enable_pin_i <= 1'b1;
        wait_for("pulse clear", 1, 1'b1);
        chk_bit("regulator kept", 1'b1, power_ctl_o.logic_supply_regulator_en);
        chk_word("config kept", 16'h05A5, {5'h00, config_o[3]});
    endtask : t_pulse

    task automatic t_supply;
        @(posedge clock_i);
        motor_supply_ok_i <= 1'b0;
        cycles(6);
        chk_bit("tie low supply", 1'b1, power_ctl_o.gate_tie);
        chk_bit("port low supply", 1'b0, power_ctl_o.serial_port_en);
        @(posedge clock_i);
        motor_supply_ok_i <= 1'b1;
        wait_for("port back", 0, 1'b1);
    endtask : t_supply

    task automatic t_sleep;
        @(posedge clock_i);
        enable_pin_i <= 1'b0;
        cycles(15);
        chk_bit("not yet asleep", 1'b1, power_ctl_o.logic_supply_regulator_en);
        chk_bit("alert shutdown", 1'b0, error_alert_low_o);
        cycles(25);
        chk_bit("asleep", 1'b0, power_ctl_o.logic_supply_regulator_en);
        chk_bit("alert asleep", 1'b1, error_alert_low_o);
        frame(16'h1800, 0);
        t_wake();
        frame(16'h9800, 0);
        chk_word("sleep write", 16'h05A5, answer);
    endtask : t_sleep

    initial
    begin
        repeat (4) @(posedge clock_i);
        reset_i <= 1'b0;
        t_wake();
        t_regs();
        t_frame_err();
        t_fault();
        t_pulse();
        t_supply();
        t_sleep();
        print_verdict();
    end
endmodule : testbench
